// File: common/twr_regs.vh
// Register map, field positions, reset values and timing for the traverse block
`ifndef TWR_REGS_VH
`define TWR_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define TWR_ADDR_W          6
`define TWR_OFF_CTRL        6'h00
`define TWR_OFF_BASE_REF    6'h04
`define TWR_OFF_UPPER_EXC   6'h08
`define TWR_OFF_LOWER_EXC   6'h0C
`define TWR_OFF_UPPER_JUMP  6'h10
`define TWR_OFF_LOWER_JUMP  6'h14
`define TWR_OFF_RISE_TIME   6'h18
`define TWR_OFF_FALL_TIME   6'h1C
`define TWR_OFF_REEL_LIMIT  6'h20
`define TWR_OFF_DECREASE    6'h24
`define TWR_OFF_LOW_FLOOR   6'h28
`define TWR_OFF_STATUS      6'h2C
`define TWR_OFF_OP_TIME     6'h30
`define TWR_OFF_SPEED       6'h34

// ****************************************************************
// Field positions
// ****************************************************************
`define TWR_CTRL_COUNTER    0
`define TWR_CTRL_SYNC_OUT   1
`define TWR_CTRL_REEL_OUT   2
`define TWR_CTRL_YARN       3
`define TWR_CTRL_REINIT     4
`define TWR_STAT_END_REEL   0
`define TWR_STAT_STOPPED    1
`define TWR_STAT_ACTIVE     15

// ****************************************************************
// Reset values and limits (speed in 0.1 Hz, times in 0.1 s)
// ****************************************************************
`define TWR_RST_EXC         16'h0028
`define TWR_RST_TIME        16'h0028
`define TWR_MAX_EXC         16'h0064
`define TWR_MIN_TIME        16'h0001
`define TWR_MAX_TIME        16'h270F
`define TWR_MAX_REEL        16'h270F
`define TWR_MAX_DECREASE    16'h1766

// ****************************************************************
// Timing
// ****************************************************************
`define TWR_CLK_NS          10
`define TWR_TICK_NS         1000000
`define TWR_TICK_CYCLES     (`TWR_TICK_NS / `TWR_CLK_NS)
`define TWR_TICKS_PER_TENTH 100
`define TWR_TICKS_PER_MIN   60000

`endif

// File: rtl/twr_slope.v
// Fractional slope generator: unit steps at span units per period ticks
`timescale 1ns/100ps
`default_nettype none
module twr_slope
(
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Control
	input  wire        clr,
	input  wire        tick,
	input  wire [15:0] span,
	input  wire [31:0] period,
	// Unit step pulse
	output reg         step
);
	reg [31:0] acc;

	// Steps are paid out one per clock between ticks; ticks are far apart
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc  <= 32'h0;
			step <= 1'b0;
		end
		else if (clr)
		begin
			acc  <= 32'h0;
			step <= 1'b0;
		end
		else
		begin
			step <= 1'b0;
			if (tick)
				acc <= acc + {16'h0, span};
			else if (period != 32'h0 && acc >= period)
			begin
				acc  <= acc - period;
				step <= 1'b1;
			end
		end
	end
endmodule // twr_slope
`default_nettype wire

// File: rtl/twr_tick_div.v
// Enable-pulse divider producing one pulse every N enabled cycles
`timescale 1ns/100ps
`default_nettype none
module twr_tick_div
#(
	parameter N = 100000
)
(
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Control
	input  wire        en,
	input  wire        clr,
	// Output pulse
	output reg         tick
);
	reg [31:0] count;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= 32'h0;
			tick  <= 1'b0;
		end
		else if (clr)
		begin
			count <= 32'h0;
			tick  <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (en)
			begin
				if (count >= N - 1)
				begin
					count <= 32'h0;
					tick  <= 1'b1;
				end
				else
					count <= count + 32'h1;
			end
		end
	end
endmodule // twr_tick_div
`default_nettype wire

// File: rtl/twr_traverse.v
// Traverse wobble speed reference with reel timer and Wishbone registers
//
// Operation
// - Cycle starts only at base reference with yarn command active.
// - Yarn command at 1 starts, at 0 stops; inactive by default.
// - On withdrawal ramp back to base, then end the function.
// - Status bit 15 is 1 while the function is active.
// - Upper and lower excursions 0 to 10 Hz, default 4 Hz.
// - Rise and fall times 0.1 to 999.9 s, default 4 s.
// - Operating time reaching reel limit sets end-of-reel output.
// - Operating time readable at all times over the bus.
// - Base lowered by decrease over reel time, slope continues after.
// - Zero floor: reference reaches 0, drive stops until new run.
// - Nonzero floor: base held at the floor; cycle keeps running, dipping below it by the lower excursion.
// - Reinitialise clears alarm, operating time and restores base.
// - While reinitialise is 1, function disabled, speed equals base (0 if the drive is stopped).
// - Counter-wobble slave profile runs in antiphase to the master.
// - Master sync output drives the slave sync input.
// - Counter wobble starts at base speed, yarn active, sync present.
`timescale 1ns/100ps
`default_nettype none
`include "twr_regs.vh"
module twr_traverse
#(
	parameter TICK_CYCLES = `TWR_TICK_CYCLES,
	parameter MIN_TICKS   = `TWR_TICKS_PER_MIN
)
(
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [5:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Command inputs
	input  wire        yarnCommand,
	input  wire        reinitCommand,
	input  wire        runCommand,
	input  wire        counterWobbleSyncInput,
	input  wire        peerAtBase,
	// Outputs
	output reg  [15:0] speedReference,
	output reg         endOfReelOutput,
	output reg         counterWobbleSyncOutput,
	output reg         driveStop
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function [15:0] min16;
		input [15:0] a;
		input [15:0] b;
		begin
			min16 = (a < b) ? a : b;
		end
	endfunction

	function [15:0] lanes;
		input [15:0] old;
		input [31:0] val;
		input [3:0]  sel;
		begin
			lanes = {sel[1] ? val[15:8] : old[15:8],
				 sel[0] ? val[7:0] : old[7:0]};
		end
	endfunction

	function [15:0] clampTime;
		input [15:0] t;
		begin
			if (t < `TWR_MIN_TIME)
				clampTime = `TWR_MIN_TIME;
			else
				clampTime = min16(t, `TWR_MAX_TIME);
		end
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	localparam IDLE = 2'd0;
	localparam RISE = 2'd1;
	localparam FALL = 2'd2;
	localparam BACK = 2'd3;

	reg  [4:0]  ctrl;
	reg  [15:0] baseRef;
	reg  [15:0] upperExc;
	reg  [15:0] lowerExc;
	reg  [15:0] upperJump;
	reg  [15:0] lowerJump;
	reg  [15:0] riseTime;
	reg  [15:0] fallTime;
	reg  [15:0] reelLimit;
	reg  [15:0] decrease;
	reg  [15:0] lowFloor;
	reg  [15:0] opTime;
	reg  [15:0] decAmount;
	reg  [16:0] offset;
	reg  [1:0]  state;
	reg         stopped;
	reg         syncPrev;
	reg         runPrev;

	wire        busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        busWr  = busReq & wb_we_i;
	wire        slave  = ctrl[`TWR_CTRL_COUNTER];
	wire        yarn   = yarnCommand | ctrl[`TWR_CTRL_YARN];
	wire        reinit = reinitCommand | ctrl[`TWR_CTRL_REINIT];
	wire        active = (state != IDLE);
	wire        runRise = runCommand & ~runPrev;
	wire        syncRise = counterWobbleSyncInput & ~syncPrev;
	wire        syncFall = ~counterWobbleSyncInput & syncPrev;
	wire [15:0] jumpUp = min16(upperJump, upperExc);
	wire [15:0] jumpDn = min16(lowerJump, lowerExc);
	wire [16:0] upLim  = {1'b0, upperExc};
	wire [16:0] dnLim  = 17'h0 - {1'b0, lowerExc};
	wire [16:0] span17 = {1'b0, upperExc} + {1'b0, lowerExc};
	wire [31:0] riseP  = {16'h0, riseTime} * `TWR_TICKS_PER_TENTH;
	wire [31:0] fallP  = {16'h0, fallTime} * `TWR_TICKS_PER_TENTH;
	wire [31:0] decP   = {16'h0, reelLimit} * MIN_TICKS;

	// Lowered base, held at the floor when one is set
	wire [15:0] lowered = (baseRef > decAmount) ? baseRef - decAmount
						    : 16'h0;
	wire        atFloor = (lowFloor != 16'h0) && (lowered <= lowFloor);
	wire [15:0] effBase = atFloor ? min16(lowFloor, baseRef)
				      : lowered;
	wire [16:0] sum     = {1'b0, effBase} + offset;
	wire [15:0] nextRef = sum[16] ? 16'h0 : sum[15:0];

	// ****************************************************************
	// Ticks and slopes
	// ****************************************************************
	wire msTick;
	wire minTick;
	wire riseStep;
	wire fallStep;
	wire decStep;

	twr_tick_div #(.N(TICK_CYCLES)) uMsDiv
	(
		.clk   (clk),
		.rst_n (rst_n),
		.en    (1'b1),
		.clr   (1'b0),
		.tick  (msTick)
	);

	// Minute count restarts with each reinitialise
	twr_tick_div #(.N(MIN_TICKS)) uMinDiv
	(
		.clk   (clk),
		.rst_n (rst_n),
		.en    (msTick & active),
		.clr   (reinit),
		.tick  (minTick)
	);

	twr_slope uRise
	(
		.clk    (clk),
		.rst_n  (rst_n),
		.clr    (~active),
		.tick   (msTick),
		.span   (span17[15:0]),
		.period (riseP),
		.step   (riseStep)
	);

	twr_slope uFall
	(
		.clk    (clk),
		.rst_n  (rst_n),
		.clr    (~active),
		.tick   (msTick),
		.span   (span17[15:0]),
		.period (fallP),
		.step   (fallStep)
	);

	// Decrease spread over the reel time; a zero limit disables it
	twr_slope uDec
	(
		.clk    (clk),
		.rst_n  (rst_n),
		.clr    (reinit | (reelLimit == 16'h0)),
		.tick   (msTick & active),
		.span   (decrease),
		.period (decP),
		.step   (decStep)
	);

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl      <= 5'h0;
			baseRef   <= 16'h0;
			upperExc  <= `TWR_RST_EXC;
			lowerExc  <= `TWR_RST_EXC;
			upperJump <= 16'h0;
			lowerJump <= 16'h0;
			riseTime  <= `TWR_RST_TIME;
			fallTime  <= `TWR_RST_TIME;
			reelLimit <= 16'h0;
			decrease  <= 16'h0;
			lowFloor  <= 16'h0;
		end
		else if (busWr)
		begin
			case (wb_adr_i)
			`TWR_OFF_CTRL:
				ctrl <= wb_sel_i[0] ? wb_dat_i[4:0] : ctrl;
			`TWR_OFF_BASE_REF:
				baseRef <= lanes(baseRef, wb_dat_i, wb_sel_i);
			`TWR_OFF_UPPER_EXC:
				upperExc <= min16(lanes(upperExc, wb_dat_i,
					wb_sel_i), `TWR_MAX_EXC);
			`TWR_OFF_LOWER_EXC:
				lowerExc <= min16(lanes(lowerExc, wb_dat_i,
					wb_sel_i), `TWR_MAX_EXC);
			`TWR_OFF_UPPER_JUMP:
				upperJump <= lanes(upperJump, wb_dat_i, wb_sel_i);
			`TWR_OFF_LOWER_JUMP:
				lowerJump <= lanes(lowerJump, wb_dat_i, wb_sel_i);
			`TWR_OFF_RISE_TIME:
				riseTime <= clampTime(lanes(riseTime, wb_dat_i,
					wb_sel_i));
			`TWR_OFF_FALL_TIME:
				fallTime <= clampTime(lanes(fallTime, wb_dat_i,
					wb_sel_i));
			`TWR_OFF_REEL_LIMIT:
				reelLimit <= min16(lanes(reelLimit, wb_dat_i,
					wb_sel_i), `TWR_MAX_REEL);
			`TWR_OFF_DECREASE:
				decrease <= min16(lanes(decrease, wb_dat_i,
					wb_sel_i), `TWR_MAX_DECREASE);
			`TWR_OFF_LOW_FLOOR:
				lowFloor <= lanes(lowFloor, wb_dat_i, wb_sel_i);
			default:
				ctrl <= ctrl;
			endcase
		end
	end

	// ****************************************************************
	// Wishbone answer: one wait state, unmapped reads return zero
	// ****************************************************************
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= busReq;
			wb_dat_o <= 32'h0;
			if (busReq && !wb_we_i)
			begin
				case (wb_adr_i)
				`TWR_OFF_CTRL:       wb_dat_o <= {27'h0, ctrl};
				`TWR_OFF_BASE_REF:   wb_dat_o <= {16'h0, baseRef};
				`TWR_OFF_UPPER_EXC:  wb_dat_o <= {16'h0, upperExc};
				`TWR_OFF_LOWER_EXC:  wb_dat_o <= {16'h0, lowerExc};
				`TWR_OFF_UPPER_JUMP: wb_dat_o <= {16'h0, upperJump};
				`TWR_OFF_LOWER_JUMP: wb_dat_o <= {16'h0, lowerJump};
				`TWR_OFF_RISE_TIME:  wb_dat_o <= {16'h0, riseTime};
				`TWR_OFF_FALL_TIME:  wb_dat_o <= {16'h0, fallTime};
				`TWR_OFF_REEL_LIMIT: wb_dat_o <= {16'h0, reelLimit};
				`TWR_OFF_DECREASE:   wb_dat_o <= {16'h0, decrease};
				`TWR_OFF_LOW_FLOOR:  wb_dat_o <= {16'h0, lowFloor};
				`TWR_OFF_STATUS:
					wb_dat_o <= {16'h0, active, 13'h0,
						driveStop, endOfReelOutput};
				`TWR_OFF_OP_TIME:
					wb_dat_o <= {16'h0, opTime};
				`TWR_OFF_SPEED:
					wb_dat_o <= {16'h0, speedReference};
				default:             wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// ****************************************************************
	// Reel timer, base decrease and stop latch
	// ****************************************************************
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			opTime          <= 16'h0;
			decAmount       <= 16'h0;
			endOfReelOutput <= 1'b0;
			stopped         <= 1'b0;
			driveStop       <= 1'b0;
			runPrev         <= 1'b0;
		end
		else
		begin
			runPrev <= runCommand;
			if (reinit)
			begin
				opTime          <= 16'h0;
				decAmount       <= 16'h0;
				endOfReelOutput <= 1'b0;
			end
			else
			begin
				if (minTick && opTime != 16'hFFFF)
					opTime <= opTime + 16'h1;
				// Keeps falling past the reel time at the same slope
				if (decStep && !atFloor && lowered != 16'h0)
					decAmount <= decAmount + 16'h1;
				if (ctrl[`TWR_CTRL_REEL_OUT] &&
				    reelLimit != 16'h0 && opTime >= reelLimit)
					endOfReelOutput <= 1'b1;
			end
			// A new run command is the only way out of the stop
			if (active && lowFloor == 16'h0 &&
			    decAmount != 16'h0 && lowered == 16'h0)
				stopped <= 1'b1;
			else if (runRise)
				stopped <= 1'b0;
			driveStop <= stopped;
		end
	end

	// ****************************************************************
	// Wobble state machine
	// ****************************************************************
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state    <= IDLE;
			offset   <= 17'h0;
			syncPrev <= 1'b0;
		end
		else
		begin
			syncPrev <= counterWobbleSyncInput;
			if (reinit || stopped)
			begin
				state  <= IDLE;
				offset <= 17'h0;
			end
			else
			begin
				case (state)
				IDLE:
					// Output equals base here since offset is zero
					if (yarn && (!slave ||
					    (counterWobbleSyncInput && peerAtBase)))
						state <= (slave && counterWobbleSyncInput)
							? FALL : RISE;
				RISE:
					if (!yarn)
						state <= BACK;
					else if ((!slave && offset == upLim) ||
						 (slave && syncRise))
					begin
						offset <= offset - {1'b0, jumpUp};
						state  <= FALL;
					end
					else if (riseStep && offset != upLim)
						offset <= offset + 17'h1;
				FALL:
					if (!yarn)
						state <= BACK;
					else if ((!slave && offset == dnLim) ||
						 (slave && syncFall))
					begin
						offset <= offset + {1'b0, jumpDn};
						state  <= RISE;
					end
					else if (fallStep && offset != dnLim)
						offset <= offset - 17'h1;
				BACK:
					if (offset == 17'h0)
						state <= IDLE;
					else if (offset[16] && riseStep)
						offset <= offset + 17'h1;
					else if (!offset[16] && fallStep)
						offset <= offset - 17'h1;
				default:
					state <= IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			speedReference          <= 16'h0;
			counterWobbleSyncOutput <= 1'b0;
		end
		else
		begin
			speedReference <= stopped ? 16'h0 : nextRef;
			// Master marks its rising half for the slave to mirror
			counterWobbleSyncOutput <= ctrl[`TWR_CTRL_SYNC_OUT] &&
				!slave && state == RISE;
		end
	end
endmodule // twr_traverse
`default_nettype wire

// File: tb/twr_master_model.sv
// Behavioural master drive feeding the counter-wobble slave
`timescale 1ns/100ps
`default_nettype none
module twr_master_model
#(
	parameter HALF = 1000
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control
	input  wire logic en,
	// Link to slave
	output var  logic syncOut,
	output var  logic atBase
);
	int cnt;

	// Sync only leaves the master; a slow HALF models a sluggish peer
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncOut <= 1'b0;
			atBase  <= 1'b0;
			cnt     <= 0;
		end
		else if (!en)
		begin
			syncOut <= 1'b0;
			atBase  <= 1'b0;
			cnt     <= 0;
		end
		else
		begin
			atBase <= 1'b1;
			cnt    <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				syncOut <= ~syncOut;
		end
	end
endmodule // twr_master_model
`default_nettype wire

// File: tb/twr_monitor.sv
// Port-level assertion checker for the traverse block
`timescale 1ns/100ps
`default_nettype none
module twr_monitor
#(
	parameter TICK_CYCLES = 10,
	parameter MIN_TICKS   = 5
)
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Commands
	input wire logic        yarnCommand,
	input wire logic        reinitCommand,
	input wire logic        runCommand,
	input wire logic        counterWobbleSyncInput,
	input wire logic        peerAtBase,
	// Outputs
	input wire logic [15:0] speedReference,
	input wire logic        endOfReelOutput,
	input wire logic        counterWobbleSyncOutput,
	input wire logic        driveStop
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_follows: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
		|=> wb_ack_o) else $error("request not acked");
	a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data outside ack");
	a_reinit_clears_alarm: assert property (reinitCommand[*2]
		|-> !endOfReelOutput) else $error("alarm kept in reinit");
	a_reinit_holds_speed: assert property (reinitCommand[*4]
		|-> $stable(speedReference)) else $error("speed moved in reinit");
	a_stop_at_zero: assert property ((driveStop && !reinitCommand)
		|-> speedReference == 16'h0000) else $error("stopped off zero");
	a_stop_needs_run: assert property ((driveStop && !runCommand)
		|=> driveStop) else $error("stop left without run");
	a_alarm_cause: assert property ($rose(endOfReelOutput)
		|-> !reinitCommand && !$past(reinitCommand))
		else $error("alarm rose in reinit");

	cover property ($rose(endOfReelOutput));
	cover property ($rose(driveStop));
	cover property (reinitCommand[*4]);
	cover property ($rose(counterWobbleSyncInput) && yarnCommand);
endmodule // twr_monitor

bind twr_traverse twr_monitor #(.TICK_CYCLES(TICK_CYCLES),
	.MIN_TICKS(MIN_TICKS)) u_mon (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.yarnCommand, .reinitCommand, .runCommand, .counterWobbleSyncInput,
	.peerAtBase, .speedReference, .endOfReelOutput,
	.counterWobbleSyncOutput, .driveStop);
`default_nettype wire

// File: tb/twr_traverse_bench.sv
// Self-checking bench for the traverse wobble block
`timescale 1ns/100ps
`default_nettype none
module twr_traverse_bench;
	logic        clk, rst_n, cyc, stb, we, ack, yarn, reinit, run;
	logic        sync, peer, eor, so, stop, mEn;
	logic [5:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat;
	logic [15:0] spd;
	int          mismatches = 0, n_checks = 0, cycles = 0;

	twr_traverse #(.TICK_CYCLES(10), .MIN_TICKS(5)) dut (.clk(clk),
		.rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .yarnCommand(yarn), .reinitCommand(reinit),
		.runCommand(run), .counterWobbleSyncInput(sync),
		.peerAtBase(peer), .speedReference(spd), .endOfReelOutput(eor),
		.counterWobbleSyncOutput(so), .driveStop(stop));
	twr_master_model #(.HALF(1000)) peerDrive (.clk(clk), .rst_n(rst_n),
		.en(mEn), .syncOut(sync), .atBase(peer));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Whole run is near 11000 cycles; over three times that means a hang
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			mismatches++;
			$display("ERROR %0t timeout", $time);
			conclude();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wbx(input logic w, input logic [5:0] a,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= {16'h0000, d};
		n = 0;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 50)
		begin
			mismatches++;
			$display("ERROR %0t no bus ack", $time);
		end
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] q;
		wbx(1'b1, a, d, q);
	endtask

	task automatic rc(input logic [5:0] a, input logic [15:0] e);
		logic [15:0] q;
		wbx(1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return eor;
			1: return stop;
			2: return sync;
			default: return spd == 16'h0064;
		endcase
	endfunction

	task automatic wt(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(k) !== v && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		chk({15'h0000, pick(k)}, {15'h0000, v});
	endtask

	// Ctrl, base, excursions, upper jump, reel, decrease, floor
	task automatic cfg(input logic [15:0] c, b, e, j, r, d, f);
		wr(6'h00, c);
		wr(6'h04, b);
		wr(6'h08, e);
		wr(6'h0C, e);
		wr(6'h10, j);
		wr(6'h14, 16'h0000);
		wr(6'h18, 16'h0001);
		wr(6'h1C, 16'h0001);
		wr(6'h20, r);
		wr(6'h24, d);
		wr(6'h28, f);
	endtask

	task automatic t_regs();
		rc(6'h08, 16'h0028);
		rc(6'h18, 16'h0028);
		rc(6'h14, 16'h0000);
		rc(6'h2C, 16'h0000);
		rc(6'h38, 16'h0000);
		wr(6'h08, 16'h00FF);
		rc(6'h08, 16'h0064);
		wr(6'h18, 16'h0000);
		rc(6'h18, 16'h0001);
		wr(6'h1C, 16'hFFFF);
		rc(6'h1C, 16'h270F);
		wr(6'h2C, 16'hFFFF);
		rc(6'h2C, 16'h0000);
		$display("test regs done");
	endtask

	task automatic t_wobble();
		logic [15:0] mx, mn, dr, pv;
		int hi;
		cfg(16'h0002, 16'h0064, 16'h0002, 16'h0005, 0, 0, 0);
		repeat (4) @(posedge clk);
		chk(spd, 16'h0064);
		yarn <= 1'b1;
		rc(6'h2C, 16'h8000);
		mx = spd;
		mn = spd;
		pv = spd;
		dr = 16'h0000;
		hi = 0;
		repeat (4000)
		begin
			@(posedge clk);
			mx = (spd > mx) ? spd : mx;
			mn = (spd < mn) ? spd : mn;
			dr = (pv > spd && pv - spd > dr) ? pv - spd : dr;
			hi = hi + so;
			pv = spd;
		end
		chk(mx, 16'h0066);
		chk(mn, 16'h0062);
		chk(dr, 16'h0002);
		chk(16'(hi != 0), 16'h0001);
		yarn <= 1'b0;
		repeat (2) @(posedge clk);
		wt(3, 1'b1, 3000);
		repeat (3) @(posedge clk);
		rc(6'h2C, 16'h0000);
		$display("test wobble done");
	endtask

	task automatic t_reel();
		// Operating time kept counting through the wobble test
		reinit <= 1'b1;
		repeat (2) @(posedge clk);
		reinit <= 1'b0;
		cfg(16'h0004, 16'h0064, 16'h0002, 0, 16'h0002, 0, 0);
		yarn <= 1'b1;
		repeat (60) @(posedge clk);
		chk({15'h0000, eor}, 16'h0000);
		wt(0, 1'b1, 400);
		rc(6'h30, 16'h0002);
		reinit <= 1'b1;
		repeat (4) @(posedge clk);
		chk({15'h0000, eor}, 16'h0000);
		chk(spd, 16'h0064);
		rc(6'h30, 16'h0000);
		rc(6'h2C, 16'h0000);
		reinit <= 1'b0;
		yarn <= 1'b0;
		$display("test reel done");
	endtask

	task automatic t_decrease();
		cfg(16'h0004, 16'h0014, 0, 0, 16'h0002, 16'h000A, 0);
		yarn <= 1'b1;
		wt(0, 1'b1, 400);
		chk(16'(spd >= 16'h0009 && spd <= 16'h000B), 16'h0001);
		wt(1, 1'b1, 1000);
		chk(spd, 16'h0000);
		wr(6'h28, 16'h0005);
		chk({15'h0000, stop}, 16'h0001);
		run <= 1'b1;
		repeat (3) @(posedge clk);
		chk({15'h0000, stop}, 16'h0000);
		run <= 1'b0;
		repeat (600) @(posedge clk);
		chk(16'(spd >= 16'h0005), 16'h0001);
		rc(6'h2C, 16'h8001);
		yarn <= 1'b0;
		reinit <= 1'b1;
		repeat (3) @(posedge clk);
		reinit <= 1'b0;
		$display("test decrease done");
	endtask

	task automatic t_counter();
		logic [15:0] s0, s1;
		cfg(16'h0001, 16'h0064, 16'h0002, 0, 0, 0, 0);
		yarn <= 1'b1;
		repeat (200) @(posedge clk);
		rc(6'h2C, 16'h0000);
		mEn <= 1'b1;
		wt(2, 1'b1, 3000);
		wt(2, 1'b0, 3000);
		wt(2, 1'b1, 3000);
		s0 = spd;
		wt(2, 1'b0, 3000);
		s1 = spd;
		wt(2, 1'b1, 3000);
		chk(16'(s1 < s0), 16'h0001);
		chk(16'(spd > s1), 16'h0001);
		rc(6'h2C, 16'h8000);
		yarn <= 1'b0;
		mEn <= 1'b0;
		$display("test counter done");
	endtask

	initial
	begin
		rst_n = 1'b0;
		{cyc, stb, we, yarn, reinit, run, mEn} = 7'h00;
		adr = 6'h00;
		sel = 4'h3;
		dat = 32'h00000000;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_wobble();
		t_reel();
		t_decrease();
		t_counter();
		conclude();
	end
endmodule // twr_traverse_bench
`default_nettype wire
